// ==== gpio_share_pkg.sv ====
// Constants shared by the dual GPIO port and its bench; the pin synchroniser gets SYNC_W as a parameter.
// Assumes a 32-bit AXI4-Lite bus; register index times four is the byte
// address of each register.
package gpio_share_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_WIDE_LATCH   = 6'h03;
  localparam logic [5:0] IDX_WIDE_DIR     = 6'h07;
  localparam logic [5:0] IDX_NARROW_LATCH = 6'h08;
  localparam logic [5:0] IDX_NARROW_DIR   = 6'h0C;
  localparam logic [5:0] IDX_WIDE_KEY     = 6'h10;
  localparam logic [5:0] IDX_NARROW_KEY   = 6'h11;
  localparam logic [5:0] IDX_TIMER_SHARE  = 6'h12;
  localparam logic [5:0] IDX_OPTICAL      = 6'h13;

  // Port widths
  localparam int WIDE_W   = 8;
  localparam int NARROW_W = 5;
  localparam int SYNC_W   = WIDE_W + NARROW_W;

  // Field positions in the narrow key register
  localparam int NKEY_IE_LSB = 0;
  localparam int NKEY_PU_LSB = 4;

  // Field positions in the timer sharing register
  localparam int TSH_CH0_LSB = 0;
  localparam int TSH_CH1_LSB = 2;
  localparam int TSH_PS_LSB  = 4;

  // Prescaler code that selects the external clock pin
  localparam logic [2:0] PS_EXT_CLOCK = 3'h7;

  // Values after reset
  localparam logic [7:0] WIDE_DIR_RST   = 8'h00;
  localparam logic [4:0] NARROW_DIR_RST = 5'h00;
  localparam logic [7:0] CTRL_RST       = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== pin_sync_2ff.sv ====
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the inputs come straight from pads with no timing relation.
`timescale 1ns/1ps
module pin_sync_2ff #(
  parameter int WIDTH = 8
) (
  // Clock
  input  wire logic             i_sys_clk,
  // Asynchronous levels in, synchronous levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = i_async;
    state_next.stable = state_reg.meta;
  end

  // No reset: pin levels are meaningful only after two edges anyway
  always_ff @(posedge i_sys_clk) begin
    state_reg <= state_next;
  end

  assign o_sync = state_reg.stable;

endmodule

// ==== dual_gpio_port.sv ====
// Dual GPIO port (8-bit wide port, 5-bit narrow port) with AXI4-Lite
// registers. Assumes keyboard and timer logic outside on i_sys_clk.
//
// Summary of operation
// - Wide port latches survive reset untouched
// - Wide direction one drives pin; reset clears
// - Wide read: latch if output, pin if input
// - Data writes load the latch only when lane 0 is strobed
// - Keyboard-enabled wide pins get pull-ups
// - Wide key enables turn pins into interrupts
// - Narrow port has five latch bits
// - Timer overrides narrow direction on its pins
// - Narrow direction still picks read source
// - Channel select bits claim narrow pins 2,1
// - External clock select feeds pin 0 to timer
// - Narrow pull-ups only while pin is input
// - Narrow key enables make pins 3..0 interrupts
// - Narrow direction one drives pin; reset clears
// - Narrow read: latch if output, pin if input
// - Two optical input circuit enable bits
`timescale 1ns/1ps
module dual_gpio_port
  import gpio_share_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  // AXI4-Lite write response
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Wide port pins
  input  wire logic [7:0]        i_wide_pin,
  output logic [7:0]             o_wide_pin,
  output logic [7:0]             o_wide_pin_oe_n,
  output logic [7:0]             o_wide_pullup_en,
  // Narrow port pins
  input  wire logic [4:0]        i_narrow_pin,
  output logic [4:0]             o_narrow_pin,
  output logic [4:0]             o_narrow_pin_oe_n,
  output logic [3:0]             o_narrow_pullup_en,
  output logic [1:0]             o_optical_enable,
  // Keyboard module side
  output logic [7:0]             o_wide_key_input,
  output logic [7:0]             o_wide_key_irq_enable,
  output logic [3:0]             o_narrow_key_input,
  output logic [3:0]             o_narrow_key_irq_enable,
  // Timer module side
  input  wire logic [1:0]        i_counter_ch_out,
  input  wire logic [1:0]        i_counter_ch_drive,
  output logic [1:0]             o_counter_ch_in,
  output logic [1:0]             o_counter_ch_in_use,
  output logic                   o_counter_ext_clock,
  output logic                   o_counter_ext_selected
);

  typedef struct packed {
    logic [7:0]  wide_latch;
    logic [7:0]  wide_dir;
    logic [4:0]  narrow_latch;
    logic [4:0]  narrow_dir;
    logic [7:0]  wide_key;
    logic [7:0]  narrow_key;
    logic [7:0]  timer_share;
    logic [1:0]  optical;
    logic        aw_held;
    logic [5:0]  aw_idx;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } port_state_t;

  port_state_t state_reg;
  port_state_t state_next;

  logic [12:0] pin_sync;
  logic [7:0]  wide_in;
  logic [4:0]  narrow_in;
  logic [1:0]  ch_in_use;
  logic        ext_sel;
  logic [4:0]  narrow_drive;
  logic [4:0]  narrow_value;
  logic        write_go;
  logic        read_go;
  logic [5:0]  ar_idx;

  // Registered pad levels, read by the port reads and the keyboard and timer views
  pin_sync_2ff #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_async   ({i_narrow_pin, i_wide_pin}),
    .o_sync    (pin_sync)
  );

  assign wide_in   = pin_sync[7:0];
  assign narrow_in = pin_sync[12:8];

  // Known offsets answer OKAY; anything else is a slave error
  function automatic logic is_mapped(input logic [5:0] idx);
    case (idx)
      IDX_WIDE_LATCH, IDX_WIDE_DIR, IDX_NARROW_LATCH, IDX_NARROW_DIR,
      IDX_WIDE_KEY, IDX_NARROW_KEY, IDX_TIMER_SHARE,
      IDX_OPTICAL: is_mapped = 1'b1;
      default:     is_mapped = 1'b0;
    endcase
  endfunction

  // Per-bit source choice for a port read
  function automatic logic [7:0] pick(input logic [7:0] dir,
                                      input logic [7:0] latch,
                                      input logic [7:0] pin);
    pick = (dir & latch) | (~dir & pin);
  endfunction

  // Timer ownership of the narrow port pins
  always_comb begin
    ch_in_use[0] = |state_reg.timer_share[TSH_CH0_LSB +: 2];
    ch_in_use[1] = |state_reg.timer_share[TSH_CH1_LSB +: 2];
    ext_sel = state_reg.timer_share[TSH_PS_LSB +: 3]
              == PS_EXT_CLOCK;
  end

  // Narrow pin drive: timer owns channel pins, ext clock pin is input
  always_comb begin
    narrow_drive = state_reg.narrow_dir;
    narrow_value = state_reg.narrow_latch;
    if (ch_in_use[0]) begin
      narrow_drive[1] = i_counter_ch_drive[0];
      narrow_value[1] = i_counter_ch_out[0];
    end
    if (ch_in_use[1]) begin
      narrow_drive[2] = i_counter_ch_drive[1];
      narrow_value[2] = i_counter_ch_out[1];
    end
    if (ext_sel) begin
      narrow_drive[0] = 1'b0;
    end
  end

  assign ar_idx    = i_araddr[7:2];
  assign o_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign o_wready  = !state_reg.w_held && !state_reg.bvalid;
  assign o_arready = !state_reg.rvalid;
  assign write_go  = state_reg.aw_held && state_reg.w_held &&
                     !state_reg.bvalid;
  assign read_go   = i_arvalid && o_arready;

  // Bus slave and register file; one write and one read in flight
  always_comb begin
    state_next = state_reg;
    // Address and data may arrive in either order
    if (i_awvalid && o_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_idx  = i_awaddr[7:2];
    end
    if (i_wvalid && o_wready) begin
      state_next.w_held  = 1'b1;
      state_next.w_data  = i_wdata[7:0];
      state_next.w_lane0 = i_wstrb[0];
    end
    if (state_reg.bvalid && i_bready) begin
      state_next.bvalid = 1'b0;
    end
    // Registers hold only lane 0; other lanes are ignored
    if (write_go) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = is_mapped(state_reg.aw_idx) ?
                           RESP_OKAY : RESP_SLVERR;
      if (state_reg.w_lane0) begin
        case (state_reg.aw_idx)
          IDX_WIDE_LATCH: begin
            state_next.wide_latch = state_reg.w_data;
          end
          IDX_WIDE_DIR: begin
            state_next.wide_dir = state_reg.w_data;
          end
          IDX_NARROW_LATCH: begin
            state_next.narrow_latch = state_reg.w_data[4:0];
          end
          IDX_NARROW_DIR: begin
            state_next.narrow_dir = state_reg.w_data[4:0];
          end
          IDX_WIDE_KEY: begin
            state_next.wide_key = state_reg.w_data;
          end
          IDX_NARROW_KEY: begin
            state_next.narrow_key = state_reg.w_data;
          end
          IDX_TIMER_SHARE: begin
            state_next.timer_share = {1'b0, state_reg.w_data[6:0]};
          end
          IDX_OPTICAL: begin
            state_next.optical = state_reg.w_data[1:0];
          end
          default: begin
            state_next.optical = state_reg.optical;
          end
        endcase
      end
    end
    if (state_reg.rvalid && i_rready) begin
      state_next.rvalid = 1'b0;
    end
    // Read data is captured at the address handshake
    if (read_go) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      case (ar_idx)
        IDX_WIDE_LATCH: begin
          state_next.rdata = pick(state_reg.wide_dir,
                                  state_reg.wide_latch, wide_in);
        end
        IDX_WIDE_DIR: begin
          state_next.rdata = state_reg.wide_dir;
        end
        IDX_NARROW_LATCH: begin
          state_next.rdata = pick({3'h0, state_reg.narrow_dir},
                                  {3'h0, state_reg.narrow_latch},
                                  {3'h0, narrow_in});
        end
        IDX_NARROW_DIR: begin
          state_next.rdata = {3'h0, state_reg.narrow_dir};
        end
        IDX_WIDE_KEY: begin
          state_next.rdata = state_reg.wide_key;
        end
        IDX_NARROW_KEY: begin
          state_next.rdata = state_reg.narrow_key;
        end
        IDX_TIMER_SHARE: begin
          state_next.rdata = state_reg.timer_share;
        end
        IDX_OPTICAL: begin
          state_next.rdata = {6'h00, state_reg.optical};
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
    // Reset leaves both data latches alone
    if (!i_reset_n) begin
      state_next             = '0;
      state_next.wide_latch   = state_reg.wide_latch;
      state_next.narrow_latch = state_reg.narrow_latch;
      state_next.wide_dir     = WIDE_DIR_RST;
      state_next.narrow_dir   = NARROW_DIR_RST;
      state_next.wide_key     = CTRL_RST;
      state_next.narrow_key   = CTRL_RST;
      state_next.timer_share  = CTRL_RST;
    end
  end

  // Single state register; synchronous reset lives in the copy above
  always_ff @(posedge i_sys_clk) begin
    state_reg <= state_next;
  end

  // Bus outputs
  assign o_bvalid = state_reg.bvalid;
  assign o_bresp  = state_reg.bresp;
  assign o_rvalid = state_reg.rvalid;
  assign o_rresp  = state_reg.rresp;
  assign o_rdata  = {24'h00_0000, state_reg.rdata};

  // Wide port pads; active-low enable while driving
  assign o_wide_pin       = state_reg.wide_latch;
  assign o_wide_pin_oe_n  = ~state_reg.wide_dir;
  assign o_wide_pullup_en = state_reg.wide_key;

  // Narrow port pads; pull-ups only where the pad is not driven
  assign o_narrow_pin       = narrow_value;
  assign o_narrow_pin_oe_n  = ~narrow_drive;
  assign o_narrow_pullup_en =
    state_reg.narrow_key[NKEY_PU_LSB +: 4] & ~narrow_drive[3:0];
  assign o_optical_enable   = state_reg.optical;

  // Keyboard module view of the pins
  assign o_wide_key_input        = wide_in;
  assign o_wide_key_irq_enable   = state_reg.wide_key;
  assign o_narrow_key_input      = narrow_in[3:0];
  assign o_narrow_key_irq_enable =
    state_reg.narrow_key[NKEY_IE_LSB +: 4];

  // Timer view of the shared pins
  assign o_counter_ch_in        = narrow_in[2:1];
  assign o_counter_ch_in_use    = ch_in_use;
  assign o_counter_ext_clock    = ext_sel & narrow_in[0];
  assign o_counter_ext_selected = ext_sel;

  // Checks of the pin and register behaviour
  AST_DIR_RESET: assert property (@(posedge i_sys_clk)
    !i_reset_n |=> (o_wide_pin_oe_n == 8'hFF) && (state_reg.narrow_dir == 5'h00))
    else $error("direction bits not cleared by reset");

  AST_LATCH_KEEP: assert property (@(posedge i_sys_clk)
    !i_reset_n |=> $stable(state_reg.wide_latch))
    else $error("wide latch changed by reset");

  AST_WIDE_READ: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (read_go && ar_idx == IDX_WIDE_LATCH) |=> o_rvalid &&
    o_rdata[7:0] == (($past(state_reg.wide_dir) & $past(state_reg.wide_latch))
    | (~$past(state_reg.wide_dir) & $past(wide_in))))
    else $error("wide port read source wrong");

  AST_WRITE_LATCH: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (write_go && state_reg.w_lane0 && state_reg.aw_idx == IDX_WIDE_LATCH)
    |=> o_wide_pin == $past(state_reg.w_data) && o_bvalid)
    else $error("wide latch write lost");

  AST_KEY_PULLUP: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    o_wide_key_irq_enable == o_wide_pullup_en)
    else $error("keyboard pin without pull-up");

  AST_TIMER_OWNS: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    ch_in_use[1] |-> o_narrow_pin_oe_n[2] == !i_counter_ch_drive[1])
    else $error("timer pin direction not from timer");

  AST_NARROW_READ: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (read_go && ar_idx == IDX_NARROW_LATCH) |=> o_rdata[7:5] == 3'h0 &&
    o_rdata[4:0] == (($past(state_reg.narrow_dir) &
    $past(state_reg.narrow_latch)) | (~$past(state_reg.narrow_dir) &
    $past(narrow_in))))
    else $error("narrow port read source wrong");

  AST_PULLUP_INPUT: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (o_narrow_pullup_en & ~o_narrow_pin_oe_n[3:0]) == 4'h0)
    else $error("pull-up on driven narrow pin");

  AST_EXT_CLOCK: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    !ext_sel |-> !o_counter_ext_clock)
    else $error("timer clock fed while not selected");

  AST_WRITE_RESP: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    write_go |=> o_bvalid [*1] ##0 !o_awready && !o_wready)
    else $error("write response missing");

endmodule

// ==== gpio_pad_model.sv ====
// Pad-side model of both ports: external drivers, pull-ups, float.
// Assumes oe_n low wherever the design drives a pad.
`timescale 1ns/1ps
module gpio_pad_model (
  // Clock
  input  wire logic       i_sys_clk,
  // Wide port pads
  input  wire logic [7:0] i_wide_out,
  input  wire logic [7:0] i_wide_oe_n,
  input  wire logic [7:0] i_wide_pullup,
  input  wire logic [7:0] i_wide_ext,
  input  wire logic [7:0] i_wide_ext_en,
  output logic      [7:0] o_wide_level,
  // Narrow port pads
  input  wire logic [4:0] i_narrow_out,
  input  wire logic [4:0] i_narrow_oe_n,
  input  wire logic [3:0] i_narrow_pullup,
  input  wire logic [4:0] i_narrow_ext,
  input  wire logic [4:0] i_narrow_ext_en,
  output logic      [4:0] o_narrow_level
);
  logic [12:0] float_reg = 13'h0000;
  logic [4:0]  narrow_pu;

  // Undriven pads wander every cycle so a stale level is never trusted
  always @(posedge i_sys_clk) begin
    float_reg <= ~float_reg;
  end

  // Pin 4 has no pull-up
  assign narrow_pu = {1'b0, i_narrow_pullup};

  // Design first, then external driver, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!i_wide_oe_n[i]) o_wide_level[i] = i_wide_out[i];
      else if (i_wide_ext_en[i]) o_wide_level[i] = i_wide_ext[i];
      else if (i_wide_pullup[i]) o_wide_level[i] = 1'b1;
      else o_wide_level[i] = float_reg[i];
    end
    for (int i = 0; i < 5; i++) begin
      if (!i_narrow_oe_n[i]) o_narrow_level[i] = i_narrow_out[i];
      else if (i_narrow_ext_en[i]) o_narrow_level[i] = i_narrow_ext[i];
      else if (narrow_pu[i]) o_narrow_level[i] = 1'b1;
      else o_narrow_level[i] = float_reg[8+i];
    end
  end
endmodule

// ==== dual_gpio_port_keyboard_timer_share_tb_top.sv ====
// Self-checking bench for the dual GPIO port, one task per scenario.
// Assumes the pad model resolves every pin level.
`timescale 1ns/1ps
module dual_gpio_port_keyboard_timer_share_tb_top
  import gpio_share_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  ch_out = 2'h0, ch_drive = 2'h0;
  logic [7:0]  wide_ext = 8'h00, wide_ext_en = 8'h00;
  logic [4:0]  narrow_ext = 5'h00, narrow_ext_en = 5'h00;
  logic        awready, wready, bvalid, arready, rvalid, ext_clk, ext_sel;
  logic [1:0]  bresp, rresp, optical, ch_in, ch_in_use;
  logic [31:0] rdata, rd;
  logic [1:0]  rsp;
  logic [7:0]  wide_lvl, wide_out, wide_oe_n, wide_pu, wide_key, wide_kie;
  logic [4:0]  narrow_lvl, narrow_out, narrow_oe_n;
  logic [3:0]  narrow_pu, narrow_key, narrow_kie;
  int          mismatches = 0;
  int          n_compared = 0;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  dual_gpio_port dual_gpio_port_inst (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_wide_pin(wide_lvl), .o_wide_pin(wide_out),
    .o_wide_pin_oe_n(wide_oe_n), .o_wide_pullup_en(wide_pu),
    .i_narrow_pin(narrow_lvl), .o_narrow_pin(narrow_out),
    .o_narrow_pin_oe_n(narrow_oe_n), .o_narrow_pullup_en(narrow_pu),
    .o_optical_enable(optical), .o_wide_key_input(wide_key),
    .o_wide_key_irq_enable(wide_kie), .o_narrow_key_input(narrow_key),
    .o_narrow_key_irq_enable(narrow_kie), .i_counter_ch_out(ch_out),
    .i_counter_ch_drive(ch_drive), .o_counter_ch_in(ch_in),
    .o_counter_ch_in_use(ch_in_use), .o_counter_ext_clock(ext_clk),
    .o_counter_ext_selected(ext_sel));

  gpio_pad_model gpio_pad_model_inst (
    .i_sys_clk(sys_clk), .i_wide_out(wide_out), .i_wide_oe_n(wide_oe_n),
    .i_wide_pullup(wide_pu), .i_wide_ext(wide_ext),
    .i_wide_ext_en(wide_ext_en), .o_wide_level(wide_lvl),
    .i_narrow_out(narrow_out), .i_narrow_oe_n(narrow_oe_n),
    .i_narrow_pullup(narrow_pu), .i_narrow_ext(narrow_ext),
    .i_narrow_ext_en(narrow_ext_en), .o_narrow_level(narrow_lvl));

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // A hung handshake counts as a failure and ends the run
  task automatic timed_out();
    mismatches++;
    $display("mismatch at %0t: bus wait timed out", $time);
    summarize();
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic bus_write(input logic [5:0] idx, input logic [7:0] data,
                           input logic [3:0] strb, output logic [1:0] resp);
    logic a_done, w_done, got;
    int   n;
    a_done = 1'b0;
    w_done = 1'b0;
    got = 1'b0;
    n = 0;
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, data};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge sys_clk);
      n++;
      if (n > 50) timed_out();
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
      if (!a_done && awready) begin
        a_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
  endtask

  task automatic bus_read(input logic [5:0] idx, output logic [31:0] data,
                          output logic [1:0] resp);
    logic a_done, got;
    int   n;
    a_done = 1'b0;
    got = 1'b0;
    n = 0;
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge sys_clk);
      n++;
      if (n > 50) timed_out();
      if (a_done && rvalid) begin
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
      if (!a_done && arready) begin
        a_done = 1'b1;
        arvalid <= 1'b0;
      end
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] data);
    bus_write(idx, data, 4'h1, rsp);
    check(rsp, RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    bus_read(idx, rd, rsp);
    check(rd, {24'h00_0000, exp});
    check(rsp, RESP_OKAY);
  endtask

  task automatic t_reset();
    check(wide_oe_n, 8'hFF);
    check(narrow_oe_n, 5'h1F);
    rd_chk(IDX_WIDE_DIR, 8'h00);
    rd_chk(IDX_NARROW_DIR, 8'h00);
  endtask

  // Latch written before direction so no glitch reaches the pad
  task automatic t_wide();
    wide_ext <= 8'h3C;
    wide_ext_en <= 8'hFF;
    wr(IDX_WIDE_LATCH, 8'hA5);
    wait_clk(4);
    rd_chk(IDX_WIDE_LATCH, 8'h3C);
    check(wide_out, 8'hA5);
    wide_ext_en <= 8'hF0;
    wr(IDX_WIDE_DIR, 8'h0F);
    wait_clk(4);
    rd_chk(IDX_WIDE_LATCH, 8'h35);
    check(wide_oe_n, 8'hF0);
    reset_n <= 1'b0;
    wait_clk(2);
    check(wide_oe_n, 8'hFF);
    reset_n <= 1'b1;
    wide_ext_en <= 8'h00;
    wr(IDX_WIDE_DIR, 8'hFF);
    rd_chk(IDX_WIDE_LATCH, 8'hA5);
  endtask

  task automatic t_narrow();
    narrow_ext <= 5'h0A;
    narrow_ext_en <= 5'h1F;
    wr(IDX_NARROW_LATCH, 8'hFF);
    wait_clk(4);
    rd_chk(IDX_NARROW_LATCH, 8'h0A);
    narrow_ext_en <= 5'h00;
    wr(IDX_NARROW_DIR, 8'hFF);
    rd_chk(IDX_NARROW_DIR, 8'h1F);
    rd_chk(IDX_NARROW_LATCH, 8'h1F);
    check(narrow_oe_n, 5'h00);
    wr(IDX_NARROW_DIR, 8'h06);
    narrow_ext_en <= 5'h19;
    wait_clk(4);
    rd_chk(IDX_NARROW_LATCH, 8'h0E);
    check(narrow_out, 5'h1F);
  endtask

  task automatic t_keys();
    wr(IDX_WIDE_KEY, 8'h81);
    check(wide_pu, 8'h81);
    check(wide_kie, 8'h81);
    check(wide_key, 8'hA5);
    wr(IDX_NARROW_KEY, 8'hF5);
    check(narrow_kie, 4'h5);
    check(narrow_pu, 4'h9);
    check(narrow_key, 4'hE);
  endtask

  // Channel 0 claims pin 1, external clock claims pin 0
  task automatic t_timer();
    narrow_ext <= 5'h00;
    narrow_ext_en <= 5'h18;
    wr(IDX_NARROW_DIR, 8'h07);
    ch_drive <= 2'b01;
    wr(IDX_TIMER_SHARE, 8'h71);
    check(ch_in_use, 2'b01);
    check(ext_sel, 1'b1);
    check(narrow_oe_n, 5'h19);
    check(narrow_out[1], 1'b0);
    ch_drive <= 2'b00;
    narrow_ext_en <= 5'h1B;
    wait_clk(4);
    check(narrow_oe_n[1], 1'b1);
    rd_chk(IDX_NARROW_LATCH, 8'h07);
    check(ch_in[0], 1'b0);
    narrow_ext <= 5'h01;
    wait_clk(4);
    check(ext_clk, 1'b1);
    narrow_ext_en <= 5'h1A;
    wr(IDX_TIMER_SHARE, 8'h0C);
    check(ext_sel, 1'b0);
    check(ext_clk, 1'b0);
    check(ch_in_use, 2'b10);
    check(narrow_oe_n, 5'h1C);
    ch_drive <= 2'b10;
    wait_clk(2);
    check(narrow_out[2], 1'b0);
    check(narrow_oe_n[2], 1'b0);
  endtask

  // Unmapped place, empty strobe, optical enables
  task automatic t_bus();
    bus_write(6'h3F, 8'h12, 4'h1, rsp);
    check(rsp, RESP_SLVERR);
    bus_read(6'h3F, rd, rsp);
    check(rd, 32'h0000_0000);
    check(rsp, RESP_SLVERR);
    bus_write(IDX_WIDE_LATCH, 8'h00, 4'h0, rsp);
    check(rsp, RESP_OKAY);
    rd_chk(IDX_WIDE_LATCH, 8'hA5);
    wr(IDX_OPTICAL, 8'h03);
    check(optical, 2'b11);
  endtask

  initial begin
    wait_clk(2);
    reset_n <= 1'b1;
    t_reset();
    t_wide();
    t_narrow();
    t_keys();
    t_timer();
    t_bus();
    summarize();
  end
endmodule
